/* src/rst_seq.sv */
`timescale 1ns/1ps
module rst_seq #(
   parameter int REL_FIRST_LVD   = rst_seq_pkg::REL_FIRST_LVD_CYC,
   parameter int REL_FIRST_NOLVD = rst_seq_pkg::REL_FIRST_NOLVD_CYC,
   parameter int REL_NEXT_LVD    = rst_seq_pkg::REL_NEXT_LVD_CYC,
   parameter int REL_NEXT_NOLVD  = rst_seq_pkg::REL_NEXT_NOLVD_CYC,
   parameter int STAB_WAIT       = rst_seq_pkg::STAB_WAIT_CYC
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        ext_reset_n,
   input  wire logic        wdt_overflow,
   input  wire logic        illegal_instr,
   input  wire logic        ram_parity_err,
   input  wire logic        illegal_access,
   input  wire logic        por_supply_ok,
   input  wire logic        lvd_supply_ok,
   input  wire logic        low_voltage_detector_en,
   input  wire logic        sw_reset_out_high,
   output logic             cpu_reset,
   output logic             cpu_clk_en,
   output logic [15:0]      cpu_vector_addr,
   output logic             high_speed_internal_osc_en,
   output logic             main_crystal_osc_en,
   output logic             main_clk_in_en,
   output logic             sub_crystal_osc_en,
   output logic             sub_clk_in_en,
   output logic             low_speed_osc_en,
   output logic             reset_output_port_pin_o,
   output logic             reset_output_port_pin_oe,
   output logic             pullup_port_pin_pu_en,
   output logic             rtc_calendar_en,
   output logic             rtc_ctrl_en
);
   localparam int CW = rst_seq_pkg::CNT_W;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   // async pins pass two flops; first stage read only by second
   logic [2:0] meta_ff, sync_ff;
   logic [2:0] nxt_meta, nxt_sync;
   always_comb begin
      nxt_meta = {lvd_supply_ok, por_supply_ok, ext_reset_n};
      nxt_sync = meta_ff;
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         meta_ff <= 3'h0;
         sync_ff <= 3'h0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end
   logic ext_ok, por_ok, lvd_ok;
   assign ext_ok = sync_ff[0];
   assign por_ok = sync_ff[1];
   assign lvd_ok = sync_ff[2];

   // ----------------------------------------------------------------
   // cause merge and sequencer
   // ----------------------------------------------------------------
   logic internal_cause, por_cause, pin_cause, lvd_cause, any_cause;
   assign pin_cause      = !ext_ok;
   assign internal_cause = wdt_overflow | illegal_instr | ram_parity_err | illegal_access;
   assign por_cause      = !por_ok;
   assign lvd_cause      = low_voltage_detector_en & !lvd_ok;
   assign any_cause      = pin_cause | internal_cause | por_cause | lvd_cause;

   rst_seq_pkg::rsq_state_e state_ff, nxt_state;
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic          first_ff, nxt_first;      // no power-on release seen yet
   logic          powerup_ff, nxt_powerup;  // stabilization wait still owed
   logic          porflag_ff, nxt_porflag;  // reset includes a power-on cause
   logic          pinflag_ff, nxt_pinflag;
   logic          rstout_ff, nxt_rstout;
   logic [CW-1:0] rel_cyc;

   // release time picked by power-on history and lvd use
   always_comb begin
      if (first_ff)
         rel_cyc = low_voltage_detector_en ? CW'(REL_FIRST_LVD) : CW'(REL_FIRST_NOLVD);
      else
         rel_cyc = low_voltage_detector_en ? CW'(REL_NEXT_LVD) : CW'(REL_NEXT_NOLVD);
   end

   always_comb begin
      nxt_state   = state_ff;
      nxt_cnt     = cnt_ff;
      nxt_first   = first_ff;
      nxt_powerup = powerup_ff;
      nxt_porflag = porflag_ff;
      nxt_pinflag = pinflag_ff;
      nxt_rstout  = rstout_ff;
      if (any_cause) begin
         nxt_rstout = 1'b0;
      end else if (sw_reset_out_high && state_ff == rst_seq_pkg::RSQ_IDLE) begin
         nxt_rstout = 1'b1;
      end
      unique case (state_ff)
         rst_seq_pkg::RSQ_IDLE: begin
            if (any_cause) begin
               nxt_state   = rst_seq_pkg::RSQ_HOLD;
               nxt_porflag = por_cause;
               nxt_pinflag = pin_cause;
            end
         end
         rst_seq_pkg::RSQ_HOLD: begin
            nxt_porflag = porflag_ff | por_cause;
            nxt_pinflag = pin_cause;
            if (!any_cause) begin
               nxt_cnt = '0;
               if (powerup_ff)
                  nxt_state = rst_seq_pkg::RSQ_STAB;
               else
                  nxt_state = rst_seq_pkg::RSQ_PROC;
            end
         end
         rst_seq_pkg::RSQ_STAB: begin
            // a fresh pin or power-on cause floats the pull-up at once,
            // not one cycle late after the trip back through hold
            nxt_porflag = porflag_ff | por_cause;
            nxt_pinflag = pin_cause;
            if (any_cause) begin
               nxt_state = rst_seq_pkg::RSQ_HOLD;
            end else if (cnt_ff >= CW'(STAB_WAIT - 1)) begin
               nxt_cnt     = '0;
               nxt_powerup = 1'b0;
               nxt_state   = rst_seq_pkg::RSQ_PROC;
            end else begin
               nxt_cnt = cnt_ff + CW'(1);
            end
         end
         rst_seq_pkg::RSQ_PROC: begin
            nxt_porflag = porflag_ff | por_cause;
            nxt_pinflag = pin_cause;
            if (any_cause) begin
               nxt_state = rst_seq_pkg::RSQ_HOLD;
            end else if (cnt_ff >= rel_cyc - CW'(1)) begin
               nxt_state = rst_seq_pkg::RSQ_IDLE;
               if (porflag_ff)
                  nxt_first = 1'b0;
               nxt_porflag = 1'b0;
            end else begin
               nxt_cnt = cnt_ff + CW'(1);
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff   <= rst_seq_pkg::RSQ_HOLD;
         cnt_ff     <= '0;
         first_ff   <= 1'b1;
         powerup_ff <= 1'b1;
         porflag_ff <= 1'b1;
         pinflag_ff <= 1'b1;
         rstout_ff  <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         first_ff   <= nxt_first;
         powerup_ff <= nxt_powerup;
         porflag_ff <= nxt_porflag;
         pinflag_ff <= nxt_pinflag;
         rstout_ff  <= nxt_rstout;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   logic in_reset;
   assign in_reset = (state_ff != rst_seq_pkg::RSQ_IDLE);
   // release is a registered state change, so synchronous to clk
   assign cpu_reset                  = in_reset;
   assign cpu_clk_en                 = !in_reset;
   assign cpu_vector_addr            = rst_seq_pkg::RESET_VECTOR_ADDR;
   assign high_speed_internal_osc_en = !in_reset;
   assign main_crystal_osc_en        = 1'b0;
   assign main_clk_in_en             = !in_reset;
   assign sub_crystal_osc_en         = 1'b1;
   assign sub_clk_in_en              = !in_reset;
   assign low_speed_osc_en           = !in_reset;
   assign reset_output_port_pin_o    = rstout_ff;
   assign reset_output_port_pin_oe   = 1'b1;
   // floats during pin or power-on reset only
   assign pullup_port_pin_pu_en      = !(in_reset && (pinflag_ff || porflag_ff));
   assign rtc_calendar_en            = 1'b1;
   assign rtc_ctrl_en                = !(in_reset && porflag_ff);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   int unsigned rel_len;
   always_ff @(posedge clk) begin
      if (reset || state_ff != rst_seq_pkg::RSQ_PROC)
         rel_len <= 0;
      else
         rel_len <= rel_len + 1;
   end

   cause_holds_a: assert property (any_cause |=> cpu_reset)
      else $error("reset not held while a cause is active");
   rstout_low_a: assert property (any_cause |=> !reset_output_port_pin_o)
      else $error("reset output not low during reset");
   clk_gated_a: assert property (cpu_reset |-> !cpu_clk_en && !high_speed_internal_osc_en)
      else $error("cpu clock or fast osc running in reset");
   slow_osc_a: assert property (cpu_reset |-> !low_speed_osc_en && !sub_clk_in_en)
      else $error("slow osc or sub clock active in reset");
   rel_bound_a: assert property (rel_len <= REL_FIRST_LVD)
      else $error("release time exceeds maximum");
   release_run_a: assert property ($fell(cpu_reset) |-> high_speed_internal_osc_en)
      else $error("released without fast osc");
   rtc_por_a: assert property (cpu_reset && porflag_ff |-> !rtc_ctrl_en && rtc_calendar_en)
      else $error("rtc control running in power-on reset");
   pullup_a: assert property (!cpu_reset |-> pullup_port_pin_pu_en)
      else $error("pull-up off outside reset");
   stab_a: assert property ($rose(state_ff == rst_seq_pkg::RSQ_STAB) |-> powerup_ff)
      else $error("stabilization wait outside power-up");
   vector_a: assert property ($fell(cpu_reset) |-> cpu_vector_addr == 16'h0000)
      else $error("wrong start vector");
   main_clk_a: assert property (cpu_reset |-> !main_clk_in_en && !main_crystal_osc_en)
      else $error("main clock input or crystal active in reset");
   pin_float_a: assert property (pin_cause |=> !pullup_port_pin_pu_en)
      else $error("pull-up on during pin reset");
   por_rtc_a: assert property (por_cause |=> !rtc_ctrl_en && !pullup_port_pin_pu_en)
      else $error("rtc control or pull-up on during power-on reset");
   rstout_set_a: assert property (state_ff == rst_seq_pkg::RSQ_IDLE && !any_cause
      && sw_reset_out_high |=> reset_output_port_pin_o)
      else $error("reset output not set by software");
   stab_cnt_a: assert property (state_ff == rst_seq_pkg::RSQ_STAB |-> cnt_ff < CW'(STAB_WAIT))
      else $error("stabilization count overran");
   stab_exit_a: assert property (state_ff == rst_seq_pkg::RSQ_STAB && !any_cause
      && cnt_ff == CW'(STAB_WAIT - 1) |=> state_ff == rst_seq_pkg::RSQ_PROC)
      else $error("stabilization wait did not end on time");
   proc_exit_a: assert property (state_ff == rst_seq_pkg::RSQ_PROC && !any_cause
      && cnt_ff == rel_cyc - CW'(1) |=> !cpu_reset)
      else $error("release did not follow processing interval");
   powerup_once_a: assert property (state_ff == rst_seq_pkg::RSQ_PROC |-> !powerup_ff)
      else $error("processing started with stabilization owed");

   // ----------------------------------------------------------------
   // release gap watch
   // ----------------------------------------------------------------
   // counts from the last cause gone to cpu release; a stuck counter
   // would otherwise hold the cpu forever without any other symptom
   int unsigned gap_len_ff, nxt_gap_len;
   always_comb begin
      if (any_cause || !in_reset)
         nxt_gap_len = 0;
      else
         nxt_gap_len = gap_len_ff + 1;
   end
   always_ff @(posedge clk) begin
      if (reset)
         gap_len_ff <= 0;
      else
         gap_len_ff <= nxt_gap_len;
   end
   gap_bound_a: assert property (gap_len_ff <= STAB_WAIT + REL_FIRST_LVD + 3)
      else $error("release gap exceeds stabilization plus processing");

   // ----------------------------------------------------------------
   // cover points
   // ----------------------------------------------------------------
   lvd_rst_c: cover property (lvd_cause ##1 cpu_reset);

   pin_rst_c: cover property ($fell(ext_ok) ##[1:50] $fell(cpu_reset));
   wdt_rst_c: cover property (wdt_overflow ##1 cpu_reset ##[1:1000] !cpu_reset);
   stab_c:    cover property (state_ff == rst_seq_pkg::RSQ_STAB);
   rstout_c:  cover property ($rose(reset_output_port_pin_o));
endmodule

/* pkg/rst_seq_pkg.sv */
package rst_seq_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ            = 25_000_000;
   localparam int CLK_NS            = 40;
   // release times in nanoseconds, longest times round down
   localparam int REL_FIRST_LVD_NS  = 832_000;
   localparam int REL_FIRST_NOLVD_NS = 519_000;
   localparam int REL_NEXT_LVD_NS   = 675_000;
   localparam int REL_NEXT_NOLVD_NS = 362_000;
   localparam int STAB_WAIT_NS      = 2_300_000;
   localparam int EXT_MIN_NS        = 10_000;
   localparam int REL_FIRST_LVD_CYC   = REL_FIRST_LVD_NS / CLK_NS;
   localparam int REL_FIRST_NOLVD_CYC = REL_FIRST_NOLVD_NS / CLK_NS;
   localparam int REL_NEXT_LVD_CYC    = REL_NEXT_LVD_NS / CLK_NS;
   localparam int REL_NEXT_NOLVD_CYC  = REL_NEXT_NOLVD_NS / CLK_NS;
   localparam int STAB_WAIT_CYC       = STAB_WAIT_NS / CLK_NS;
   localparam int EXT_MIN_CYC         = (EXT_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W             = 17;
   localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;

   typedef enum logic [1:0] {
      RSQ_IDLE  = 2'b00,
      RSQ_HOLD  = 2'b01,
      RSQ_STAB  = 2'b11,
      RSQ_PROC  = 2'b10
   } rsq_state_e;
endpackage

/* bench/rsq_ext_partner.sv */
`timescale 1ns/1ps
module rsq_ext_partner #(
   parameter int HOLD = rst_seq_pkg::EXT_MIN_CYC
) (
   input  wire logic clk,
   input  wire logic start,
   input  wire logic pin_o,
   input  wire logic pin_oe,
   output logic      ext_reset_n,
   output logic      dn_held
);
   int   cnt  = 0;
   logic last = 1'b0;
   wire  level = pin_oe ? pin_o : ~last;
   // ----------------------------------------
   // reset source and downstream device
   // ----------------------------------------
   initial ext_reset_n = 1'b1;
   always @(posedge clk) begin
      if (start) cnt <= HOLD;
      else if (cnt != 0) cnt <= cnt - 1;
      ext_reset_n <= !(start || cnt > 1);
      last <= level;
   end
   // undriven pin shows inverse of last value, no pull on this net
   assign dn_held = ~level;
endmodule

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   localparam int RFL = 20, RNL = 16, RNN = 10, STB = 40;
   logic        clk = 1'b0, reset = 1'b1, ext_req = 1'b0, sw_hi = 1'b0;
   logic [3:0]  cause = 4'h0;
   logic        por_ok = 1'b1, lvd_ok = 1'b1, lvd_en = 1'b1;
   logic        ext_n, cpu_rst, clk_en, hs_en, mx_en, mci_en, sx_en, sci_en, ls_en;
   logic        rst_o, rst_oe, pu_en, cal_en, ctl_en, dn_held;
   logic [15:0] vec;
   int          errors = 0, checks = 0, cycles = 0, n;
   always #20 clk = ~clk;
   rsq_ext_partner u_rsq_ext_partner (.clk(clk), .start(ext_req), .pin_o(rst_o),
      .pin_oe(rst_oe), .ext_reset_n(ext_n), .dn_held(dn_held));
   rst_seq #(.REL_FIRST_LVD(RFL), .REL_FIRST_NOLVD(12), .REL_NEXT_LVD(RNL),
      .REL_NEXT_NOLVD(RNN), .STAB_WAIT(STB)) u_rst_seq (.clk(clk), .reset(reset),
      .ext_reset_n(ext_n), .wdt_overflow(cause[0]), .illegal_instr(cause[1]),
      .ram_parity_err(cause[2]), .illegal_access(cause[3]), .por_supply_ok(por_ok),
      .lvd_supply_ok(lvd_ok), .low_voltage_detector_en(lvd_en),
      .sw_reset_out_high(sw_hi), .cpu_reset(cpu_rst), .cpu_clk_en(clk_en),
      .cpu_vector_addr(vec), .high_speed_internal_osc_en(hs_en),
      .main_crystal_osc_en(mx_en), .main_clk_in_en(mci_en), .sub_crystal_osc_en(sx_en),
      .sub_clk_in_en(sci_en), .low_speed_osc_en(ls_en), .reset_output_port_pin_o(rst_o),
      .reset_output_port_pin_oe(rst_oe), .pullup_port_pin_pu_en(pu_en),
      .rtc_calendar_en(cal_en), .rtc_ctrl_en(ctl_en));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic complete_run;
      if (errors == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic chk_reset(logic pu, logic ctl);
      @(negedge clk);
      check("cpu_reset", cpu_rst, 1'b1);
      check("main clocks", {clk_en, hs_en, mx_en, mci_en}, 4'h0);
      check("sub clocks", {sx_en, sci_en, ls_en}, 3'h4);
      check("reset out", {rst_o, dn_held}, 2'h1);
      check("pullup", pu_en, pu);
      check("rtc", {cal_en, ctl_en}, {1'b1, ctl});
   endtask
   task automatic wait_rel(int lo, int hi);
      n = 0;
      while (cpu_rst !== 1'b0 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      check("release window", (n >= lo && n <= hi), 1'b1);
      check("run clocks", {clk_en, hs_en, mx_en, mci_en, pu_en, ctl_en}, 6'h37);
      check("vector", vec, 16'h0000);
   endtask
   task automatic pulse(logic [3:0] c);
      @(posedge clk) cause <= c;
      @(posedge clk) cause <= 4'h0;
      @(posedge clk);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_internal;
      @(posedge clk) sw_hi <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk) check("released out", {rst_o, dn_held}, 2'h2);
      for (int i = 0; i < 4; i++) begin
         pulse(4'h1 << i);
         chk_reset(1'b1, 1'b1);
         wait_rel(RNN - 2, RFL + 4);
      end
      pulse(4'h1);
      repeat (5) @(posedge clk);
      pulse(4'h4); // restart while releasing
      wait_rel(RNN - 2, RFL + 4);
   endtask
   task automatic t_ext;
      @(posedge clk) ext_req <= 1'b1;
      @(posedge clk) ext_req <= 1'b0;
      repeat (10) @(posedge clk);
      chk_reset(1'b0, 1'b1);
      n = 0;
      while (ext_n !== 1'b1 && n < 400) @(posedge clk) n++;
      wait_rel(RNN - 2, RFL + 6);
   endtask
   task automatic t_supply(logic en, int rel);
      @(posedge clk) lvd_en <= en;
      por_ok <= 1'b0;
      repeat (8) @(posedge clk);
      chk_reset(1'b0, 1'b0);
      @(posedge clk) por_ok <= 1'b1;
      wait_rel(rel, rel + 6);
   endtask
   task automatic t_lvd;
      @(posedge clk) lvd_ok <= 1'b0;
      repeat (8) @(posedge clk);
      chk_reset(1'b1, 1'b1);
      @(posedge clk) lvd_ok <= 1'b1;
      wait_rel(RNN - 2, RFL + 6);
      @(posedge clk) lvd_en <= 1'b0;
      lvd_ok <= 1'b0;
      repeat (8) @(negedge clk);
      check("lvd off", cpu_rst, 1'b0);
      @(posedge clk) lvd_ok <= 1'b1;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         errors++;
         complete_run;
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      chk_reset(1'b0, 1'b0);
      @(posedge clk) reset <= 1'b0;
      wait_rel(STB + RFL, STB + RFL + 6);
      t_internal;
      t_ext;
      t_supply(1'b0, RNN);
      t_supply(1'b1, RNL);
      t_lvd;
      complete_run;
   end
endmodule
